// *** include/tccb_cfg.svh ***
// offsets, field positions, reset values and counts of the config bank
`ifndef TCCB_CFG_SVH
`define TCCB_CFG_SVH
`define TCCB_OFS_EVT_COMMS   16'h11be
`define TCCB_OFS_SW_OSC_LP   16'h11c0
`define TCCB_OFS_WAKE_SETUP  16'h11c2
`define TCCB_NUM_BYTES       8
`define TCCB_MASK_BYTES      64'hf3ff_ffff_f0ff_ffff
`define TCCB_RST_BYTES       64'h0000_0000_0000_000c
`define TCCB_B_SNAP_EVT      15
`define TCCB_B_SWITCH_EVT    14
`define TCCB_B_TOUCH_EVT     13
`define TCCB_B_WAKE_EVT      12
`define TCCB_B_RETUNE_EVT    11
`define TCCB_B_SURF_EVT      10
`define TCCB_B_GESTURE_EVT   9
`define TCCB_B_EVENT_MODE    8
`define TCCB_B_MANUAL        7
`define TCCB_B_TERM_CMD      6
`define TCCB_B_SLEEP_CONV    5
`define TCCB_B_FORCE_REQ     4
`define TCCB_B_WAKE_RETUNE   3
`define TCCB_B_SURF_RETUNE   2
`define TCCB_B_WAKE_FULL     1
`define TCCB_B_LIGHT_SLEEP   0
`define TCCB_B_SW_EN         15
`define TCCB_B_SW_POL        14
`define TCCB_F_PROX_TRIM     13:12
`define TCCB_F_MAIN_OSC      7:6
`define TCCB_B_LP2_AP_EN     5
`define TCCB_B_LP1_AP_EN     4
`define TCCB_F_LP2_AP_CYC    3:2
`define TCCB_F_LP1_AP_CYC    1:0
`define TCCB_B_WAKE_EN       31
`define TCCB_B_WAKE_FILT     30
`define TCCB_B_WAKE_MUTUAL   29
`define TCCB_B_WAKE_SHIELD   28
`define TCCB_F_WAKE_RX       25:0
`define TCCB_MODE_LP1        3'h3
`define TCCB_MODE_LP2        3'h4
`define TCCB_AP_CYC_0        9'h010
`define TCCB_AP_CYC_1        9'h020
`define TCCB_AP_CYC_2        9'h040
`define TCCB_AP_CYC_3        9'h100
`define TCCB_TRIM_STEP       6'h0a
`endif

// *** include/tccb_pkg.sv ***
// types shared by the config bank
package tccb_pkg;
    typedef enum logic [1:0] {
        WIN_CLOSED,
        WIN_OPEN,
        WIN_TERM
    } tccb_win_e;
endpackage : tccb_pkg

// *** verilog/tccb_byte_reg.sv ***
// one writable byte of the config bank with a write mask
`timescale 1ns/100ps
module tccb_byte_reg #(
    parameter logic [7:0] MASK = 8'hff,
    parameter logic [7:0] RST  = 8'h00
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       we_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] q_o
);
    typedef struct packed {
        logic [7:0] q;
    } tccb_byte_s;

    tccb_byte_s st_reg;
    tccb_byte_s st_next;

    always_comb begin
        st_next = st_reg;
        if (we_i) begin
            st_next.q = wdata_i & MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_reg <= '{q: RST};
        end else begin
            st_reg <= st_next;
        end
    end

    assign q_o = st_reg.q;
endmodule : tccb_byte_reg

// *** verilog/tccb_config_bank.sv ***
// configuration register bank of the trackpad controller
//
// Operation
// (RL1) snap and switch toggles raise enabled events
// (RL2) touch, movement toggles raise enabled events
// (RL3) wake channel toggle raises event when enabled
// (RL4) retuning raises event when enabled
// (RL5) gestures raise event when enabled
// (RL6) window each cycle except autonomous proximity cycles, or only on events
// (RL7) manual control hands mode choice to host
// (RL8) terminate command plus stop closes window
// (RL9) sleep during conversions when bit set
// (RL10) outside window: stretch, or request by command
// (RL11) retuning enables for wake and surface
// (RL12) wake tuning: compensation only or full
// (RL13) sleep depth: deep or light
// (RL14) switch enable and active level
// (RL15) proximity oscillator trim codes
// (RL16) main oscillator selection codes
// (RL17) autonomous proximity enables per low-power mode
// (RL18) autonomous proximity cycle counts per mode
// (RL19) low-power sensing: wake or surface channels
// (RL20) wake filter enable and sensing method
// (RL21) active shield in self-capacitive wake sensing
// (RL22) receive electrode selection for wake sensor
// (RL23) reserved bits read zero, ignore writes
`timescale 1ns/100ps
`include "tccb_cfg.svh"
module tccb_config_bank
    import tccb_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [15:0] reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o,
    output logic             reg_rvalid_o,
    input  wire logic        snap_toggle_i,
    input  wire logic        switch_toggle_i,
    input  wire logic        touch_toggle_i,
    input  wire logic        wake_toggle_i,
    input  wire logic        retune_i,
    input  wire logic        surface_move_i,
    input  wire logic        gesture_i,
    input  wire logic        cycle_end_i,
    input  wire logic        auto_prox_cycle_i,
    input  wire logic        stop_i,
    input  wire logic        term_cmd_i,
    input  wire logic        window_req_i,
    input  wire logic        host_busy_i,
    input  wire logic [2:0]  host_mode_i,
    input  wire logic [2:0]  auto_mode_i,
    input  wire logic        switch_pin_i,
    output logic             event_o,
    output logic             window_open_o,
    output logic             stretch_o,
    output logic             mode_manual_o,
    output logic [2:0]       power_mode_o,
    output logic             sleep_conv_o,
    output logic             wake_retune_en_o,
    output logic             surf_retune_en_o,
    output logic             wake_full_tune_o,
    output logic             light_sleep_o,
    output logic             switch_active_o,
    output logic [1:0]       main_osc_sel_o,
    output logic [5:0]       prox_trim_pct_o,
    output logic [8:0]       autoprox_cycles_o,
    output logic             wake_sensed_o,
    output logic             wake_filter_o,
    output logic             wake_mutual_o,
    output logic             wake_shield_o,
    output logic [25:0]      wake_rx_sel_o
);
    localparam logic [63:0] MASKS = `TCCB_MASK_BYTES;
    localparam logic [63:0] RSTS  = `TCCB_RST_BYTES;

    // ************************************************************
    // register bytes
    // ************************************************************
    logic [63:0] bytes_q;
    logic [7:0]  byte_we;
    logic [15:0] evt_cfg;
    logic [15:0] sys_cfg;
    logic [31:0] wake_cfg;

    always_comb begin
        for (int i = 0; i < `TCCB_NUM_BYTES; i++) begin
            byte_we[i] = reg_wr_i && (reg_addr_i == `TCCB_OFS_EVT_COMMS + 16'(i));
        end
    end

    genvar g;
    generate
        for (g = 0; g < `TCCB_NUM_BYTES; g++) begin : g_byte
            tccb_byte_reg #(
                .MASK (MASKS[8*g +: 8]),
                .RST  (RSTS[8*g +: 8])
            ) u_byte (
                .clk_i   (clk_i),
                .rst_n_i (rst_n_i),
                .we_i    (byte_we[g]),
                .wdata_i (reg_wdata_i),
                .q_o     (bytes_q[8*g +: 8])    // [RL23]
            );
        end
    endgenerate

    assign evt_cfg  = bytes_q[15:0];
    assign sys_cfg  = bytes_q[31:16];
    assign wake_cfg = bytes_q[63:32];

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        tccb_win_e   win;
        logic        win_open;
        logic        evt_pend;
        logic        req_pend;
        logic [7:0]  rdata;
        logic        rvalid;
        logic        event_p;
        logic        stretch;
        logic        manual;
        logic [2:0]  pmode;
        logic [4:0]  misc;
        logic        sw_act;
        logic [1:0]  osc;
        logic [5:0]  trim;
        logic [8:0]  apc;
        logic        wake_sns;
        logic        filt;
        logic        mutual;
        logic        shield;
        logic [25:0] rx;
    } tccb_state_s;

    tccb_state_s st_reg;
    tccb_state_s st_next;

    logic       evt_now;
    logic       open_now;
    logic       in_lp1;
    logic       in_lp2;
    logic [2:0] mode_sel;
    logic [1:0] ap_code;
    logic [5:0] step;

    function automatic logic [8:0] ap_count(input logic [1:0] code);
        unique case (code)
            2'h0: ap_count = `TCCB_AP_CYC_0;
            2'h1: ap_count = `TCCB_AP_CYC_1;
            2'h2: ap_count = `TCCB_AP_CYC_2;
            2'h3: ap_count = `TCCB_AP_CYC_3;
        endcase
    endfunction : ap_count

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        st_next = st_reg;
        evt_now = (snap_toggle_i   && evt_cfg[`TCCB_B_SNAP_EVT])     // [RL1]
               || (switch_toggle_i && evt_cfg[`TCCB_B_SWITCH_EVT])   // [RL1]
               || (touch_toggle_i  && evt_cfg[`TCCB_B_TOUCH_EVT])    // [RL2]
               || (surface_move_i  && evt_cfg[`TCCB_B_SURF_EVT])     // [RL2]
               || (wake_toggle_i   && evt_cfg[`TCCB_B_WAKE_EVT])     // [RL3]
               || (retune_i        && evt_cfg[`TCCB_B_RETUNE_EVT])   // [RL4]
               || (gesture_i       && evt_cfg[`TCCB_B_GESTURE_EVT]); // [RL5]
        st_next.event_p = evt_now;
        // event wins over the clear done by the opening window
        if (evt_now) begin
            st_next.evt_pend = 1'b1;
        end
        if (window_req_i && evt_cfg[`TCCB_B_FORCE_REQ]) begin
            st_next.req_pend = 1'b1;                             // [RL10]
        end
        if (evt_cfg[`TCCB_B_EVENT_MODE]) begin
            open_now = cycle_end_i && (st_reg.evt_pend || evt_now);   // [RL6]
        end else begin
            open_now = cycle_end_i && !auto_prox_cycle_i;             // [RL6]
        end
        open_now = open_now || (cycle_end_i && st_reg.req_pend);
        unique case (st_reg.win)
            WIN_CLOSED: begin
                if (open_now) begin
                    st_next.win      = WIN_OPEN;
                    st_next.evt_pend = evt_now;
                    st_next.req_pend = window_req_i && evt_cfg[`TCCB_B_FORCE_REQ];
                end
            end
            WIN_OPEN: begin
                if (evt_cfg[`TCCB_B_TERM_CMD]) begin
                    if (term_cmd_i) begin
                        st_next.win = WIN_TERM;                  // [RL8]
                    end
                end else if (stop_i) begin
                    st_next.win = WIN_CLOSED;                    // [RL8]
                end
            end
            WIN_TERM: begin
                if (stop_i) begin
                    st_next.win = WIN_CLOSED;                    // [RL8]
                end
            end
        endcase
        st_next.win_open = (st_next.win != WIN_CLOSED);
        st_next.stretch = host_busy_i && (st_next.win == WIN_CLOSED)
                       && !evt_cfg[`TCCB_B_FORCE_REQ];           // [RL10]

        st_next.manual = evt_cfg[`TCCB_B_MANUAL];
        mode_sel = evt_cfg[`TCCB_B_MANUAL] ? host_mode_i : auto_mode_i;   // [RL7]
        st_next.pmode = mode_sel;
        st_next.misc = {evt_cfg[`TCCB_B_SLEEP_CONV],             // [RL9]
                        evt_cfg[`TCCB_B_WAKE_RETUNE],            // [RL11]
                        evt_cfg[`TCCB_B_SURF_RETUNE],            // [RL11]
                        evt_cfg[`TCCB_B_WAKE_FULL],              // [RL12]
                        evt_cfg[`TCCB_B_LIGHT_SLEEP]};           // [RL13]

        st_next.sw_act = sys_cfg[`TCCB_B_SW_EN]
                      && (switch_pin_i == sys_cfg[`TCCB_B_SW_POL]);   // [RL14]
        st_next.osc = sys_cfg[`TCCB_F_MAIN_OSC];                 // [RL16]
        // main oscillator code 0 starts the trim one step lower
        step = (sys_cfg[`TCCB_F_PROX_TRIM] == 2'h0) ? 6'h00
             : (sys_cfg[`TCCB_F_MAIN_OSC] == 2'h0) ? 6'h00 : `TCCB_TRIM_STEP;
        st_next.trim = 6'(`TCCB_TRIM_STEP * sys_cfg[`TCCB_F_PROX_TRIM]) + step;  // [RL15]

        in_lp1 = (mode_sel == `TCCB_MODE_LP1);
        in_lp2 = (mode_sel == `TCCB_MODE_LP2);
        ap_code = in_lp2 ? sys_cfg[`TCCB_F_LP2_AP_CYC] : sys_cfg[`TCCB_F_LP1_AP_CYC];
        if ((in_lp1 && sys_cfg[`TCCB_B_LP1_AP_EN])
            || (in_lp2 && sys_cfg[`TCCB_B_LP2_AP_EN])) begin     // [RL17]
            st_next.apc = ap_count(ap_code);                     // [RL18]
        end else begin
            st_next.apc = 9'h000;
        end

        st_next.wake_sns = wake_cfg[`TCCB_B_WAKE_EN] && (in_lp1 || in_lp2);  // [RL19]
        st_next.filt   = wake_cfg[`TCCB_B_WAKE_FILT];            // [RL20]
        st_next.mutual = wake_cfg[`TCCB_B_WAKE_MUTUAL];          // [RL20]
        st_next.shield = wake_cfg[`TCCB_B_WAKE_SHIELD]
                      && !wake_cfg[`TCCB_B_WAKE_MUTUAL];         // [RL21]
        st_next.rx = wake_cfg[`TCCB_F_WAKE_RX];                  // [RL22]

        st_next.rvalid = reg_rd_i;
        st_next.rdata  = 8'h00;
        for (int i = 0; i < `TCCB_NUM_BYTES; i++) begin
            if (reg_rd_i && (reg_addr_i == `TCCB_OFS_EVT_COMMS + 16'(i))) begin
                st_next.rdata = bytes_q[8*i +: 8];               // [RL23]
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_reg          <= '0;
            st_reg.win      <= WIN_CLOSED;
        end else begin
            st_reg <= st_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign reg_rdata_o       = st_reg.rdata;
    assign reg_rvalid_o      = st_reg.rvalid;
    assign event_o           = st_reg.event_p;
    assign window_open_o     = st_reg.win_open;
    assign stretch_o         = st_reg.stretch;
    assign mode_manual_o     = st_reg.manual;
    assign power_mode_o      = st_reg.pmode;
    assign sleep_conv_o      = st_reg.misc[4];
    assign wake_retune_en_o  = st_reg.misc[3];
    assign surf_retune_en_o  = st_reg.misc[2];
    assign wake_full_tune_o  = st_reg.misc[1];
    assign light_sleep_o     = st_reg.misc[0];
    assign switch_active_o   = st_reg.sw_act;
    assign main_osc_sel_o    = st_reg.osc;
    assign prox_trim_pct_o   = st_reg.trim;
    assign autoprox_cycles_o = st_reg.apc;
    assign wake_sensed_o     = st_reg.wake_sns;
    assign wake_filter_o     = st_reg.filt;
    assign wake_mutual_o     = st_reg.mutual;
    assign wake_shield_o     = st_reg.shield;
    assign wake_rx_sel_o     = st_reg.rx;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_snap_evt;
        snap_toggle_i && evt_cfg[`TCCB_B_SNAP_EVT] |=> event_o;
    endproperty
    a_snap_evt: assert property (p_snap_evt) // [RL1]
        else $error("enabled snap toggle raised no event");

    property p_no_evt;
        !(snap_toggle_i || switch_toggle_i || touch_toggle_i || wake_toggle_i
          || retune_i || surface_move_i || gesture_i) |=> !event_o;
    endproperty
    a_no_evt: assert property (p_no_evt) // [RL5]
        else $error("event without cause");

    property p_gesture_off;
        gesture_i && !evt_cfg[`TCCB_B_GESTURE_EVT] && !snap_toggle_i && !switch_toggle_i
        && !touch_toggle_i && !wake_toggle_i && !retune_i && !surface_move_i
        |=> !event_o;
    endproperty
    a_gesture_off: assert property (p_gesture_off) // [RL5]
        else $error("disabled gesture raised event");

    property p_poll_open;
        !window_open_o && cycle_end_i && !auto_prox_cycle_i
        && !evt_cfg[`TCCB_B_EVENT_MODE] |=> window_open_o;
    endproperty
    a_poll_open: assert property (p_poll_open) // [RL6]
        else $error("window not opened at cycle end");

    sequence s_term_armed;
        window_open_o && evt_cfg[`TCCB_B_TERM_CMD] && term_cmd_i && !stop_i;
    endsequence
    property p_term_close;
        s_term_armed ##1 !stop_i ##1 stop_i |=> !window_open_o;
    endproperty
    a_term_close: assert property (p_term_close) // [RL8]
        else $error("terminate then late stop left window open");
    property p_stop_ignored;
        st_reg.win == WIN_OPEN && evt_cfg[`TCCB_B_TERM_CMD] && stop_i && !term_cmd_i
        |=> window_open_o;
    endproperty
    a_stop_ignored: assert property (p_stop_ignored) // [RL8]
        else $error("stop closed window without terminate command");

    property p_term_stop;
        s_term_armed ##1 stop_i |=> !window_open_o;
    endproperty
    a_term_stop: assert property (p_term_stop) // [RL8]
        else $error("terminate then stop did not close window");

    property p_stretch;
        host_busy_i && !window_open_o && !open_now && evt_cfg[`TCCB_B_FORCE_REQ] == 1'b0
        |=> stretch_o;
    endproperty
    a_stretch: assert property (p_stretch) // [RL10]
        else $error("no stretch outside window");

    property p_manual_mode;
        evt_cfg[`TCCB_B_MANUAL] |=> power_mode_o == $past(host_mode_i);
    endproperty
    a_manual_mode: assert property (p_manual_mode) // [RL7]
        else $error("manual mode not taken from host");

    property p_switch;
        sys_cfg[`TCCB_B_SW_EN] && switch_pin_i == sys_cfg[`TCCB_B_SW_POL] |=> switch_active_o;
    endproperty
    a_switch: assert property (p_switch) // [RL14]
        else $error("active switch not reported");

    property p_ap256;
        auto_mode_i == `TCCB_MODE_LP2 && !evt_cfg[`TCCB_B_MANUAL]
        && sys_cfg[`TCCB_B_LP2_AP_EN] && sys_cfg[`TCCB_F_LP2_AP_CYC] == 2'h3
        |=> autoprox_cycles_o == 9'h100;
    endproperty
    a_ap256: assert property (p_ap256) // [RL18]
        else $error("wrong autonomous proximity count");

    property p_shield;
        wake_cfg[`TCCB_B_WAKE_MUTUAL] |=> !wake_shield_o;
    endproperty
    a_shield: assert property (p_shield) // [RL21]
        else $error("shield active in mutual sensing");

    property p_reserved;
        reg_rd_i && reg_addr_i == `TCCB_OFS_SW_OSC_LP + 16'h1 |=> reg_rdata_o[3:0] == 4'h0;
    endproperty
    a_reserved: assert property (p_reserved) // [RL23]
        else $error("reserved bits read nonzero");
endmodule : tccb_config_bank

// *** testbench/tccb_host_model.sv ***
// host processor model driving the register port and window commands
`timescale 1ns/100ps
module tccb_host_model (
    input  wire logic [7:0]  reg_rdata_i,
    input  wire logic        reg_rvalid_i,
    input  wire logic        clk_i,
    output logic      [15:0] reg_addr_o,
    output logic             reg_wr_o,
    output logic             reg_rd_o,
    output logic      [7:0]  reg_wdata_o,
    output logic             stop_o,
    output logic             term_cmd_o,
    output logic             window_req_o,
    output logic             host_busy_o,
    output logic      [2:0]  host_mode_o
);
    initial begin
        reg_addr_o = 16'h0000;
        reg_wdata_o = 8'h00;
        {reg_wr_o, reg_rd_o, stop_o, term_cmd_o, window_req_o, host_busy_o} = 6'h00;
        host_mode_o = 3'h0;
    end

    // ****************************************
    // one byte access, strobe over one edge
    // ****************************************
    task automatic access(input logic wr, input logic [15:0] addr, input logic [7:0] wdata,
                          output logic [7:0] rdata, output logic ok);
        @(posedge clk_i);
        #1;
        reg_addr_o = addr;
        reg_wdata_o = wdata;
        reg_wr_o = wr;
        reg_rd_o = !wr;
        @(posedge clk_i);
        #1;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        // released bus shows no stale value
        reg_addr_o = ~addr;
        reg_wdata_o = ~wdata;
        rdata = reg_rdata_i;
        ok = wr | reg_rvalid_i;
    endtask : access

    // 0 stop, 1 terminate command, 2 window request
    task automatic cmd(input int which);
        @(posedge clk_i);
        #1;
        stop_o = (which == 0);
        term_cmd_o = (which == 1);
        window_req_o = (which == 2);
        @(posedge clk_i);
        #1;
        {stop_o, term_cmd_o, window_req_o} = 3'b000;
    endtask : cmd

    task automatic set_host(input logic busy, input logic [2:0] mode);
        host_busy_o = busy;
        host_mode_o = mode;
    endtask : set_host
endmodule : tccb_host_model

// *** testbench/tb_touch_controller_config_bank.sv ***
// self-checking bench of the trackpad config bank
`timescale 1ns/100ps
`include "tccb_cfg.svh"
module tb_touch_controller_config_bank;
    localparam logic [63:0] MASK = `TCCB_MASK_BYTES;
    localparam logic [63:0] RST  = `TCCB_RST_BYTES;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [15:0] reg_addr;
    logic        reg_wr, reg_rd, reg_rvalid, stop, term_cmd, window_req, host_busy;
    logic [7:0]  reg_wdata, reg_rdata, d;
    logic [2:0]  host_mode, power_mode_o;
    logic [2:0]  auto_mode = 3'h0;
    logic [6:0]  cause = 7'h00;
    logic        c_snap, c_switch, c_touch, c_wake, c_retune, c_move, c_gesture;
    assign {c_snap, c_switch, c_touch, c_wake, c_retune, c_move, c_gesture} = cause;
    logic        cycle_end = 1'b0, auto_prox = 1'b0, switch_pin = 1'b0;
    logic        event_o, window_open_o, stretch_o, mode_manual_o, sleep_conv_o;
    logic        wake_retune_en_o, surf_retune_en_o, wake_full_tune_o, light_sleep_o;
    logic        switch_active_o, wake_sensed_o, wake_filter_o, wake_mutual_o, wake_shield_o;
    logic [1:0]  main_osc_sel_o;
    logic [5:0]  prox_trim_pct_o;
    logic [8:0]  autoprox_cycles_o;
    logic [25:0] wake_rx_sel_o;
    logic [7:0]  mem [8];
    int          miscompares = 0, total_checks = 0;
    int          aptab [4] = '{16, 32, 64, 256};

    always #12.5 clk_i = ~clk_i;

    tccb_host_model u_host (.clk_i(clk_i), .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid),
        .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata),
        .stop_o(stop), .term_cmd_o(term_cmd), .window_req_o(window_req),
        .host_busy_o(host_busy), .host_mode_o(host_mode));

    tccb_config_bank u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
        .reg_rvalid_o(reg_rvalid), .snap_toggle_i(c_snap), .switch_toggle_i(c_switch),
        .touch_toggle_i(c_touch), .wake_toggle_i(c_wake), .retune_i(c_retune),
        .surface_move_i(c_move), .gesture_i(c_gesture), .cycle_end_i(cycle_end),
        .auto_prox_cycle_i(auto_prox), .stop_i(stop), .term_cmd_i(term_cmd),
        .window_req_i(window_req), .host_busy_i(host_busy), .host_mode_i(host_mode),
        .auto_mode_i(auto_mode), .switch_pin_i(switch_pin), .event_o(event_o),
        .window_open_o(window_open_o), .stretch_o(stretch_o), .mode_manual_o(mode_manual_o),
        .power_mode_o(power_mode_o), .sleep_conv_o(sleep_conv_o),
        .wake_retune_en_o(wake_retune_en_o), .surf_retune_en_o(surf_retune_en_o),
        .wake_full_tune_o(wake_full_tune_o), .light_sleep_o(light_sleep_o),
        .switch_active_o(switch_active_o), .main_osc_sel_o(main_osc_sel_o),
        .prox_trim_pct_o(prox_trim_pct_o), .autoprox_cycles_o(autoprox_cycles_o),
        .wake_sensed_o(wake_sensed_o), .wake_filter_o(wake_filter_o),
        .wake_mutual_o(wake_mutual_o), .wake_shield_o(wake_shield_o),
        .wake_rx_sel_o(wake_rx_sel_o));

    // ****************************************
    // compare, access and closing tasks
    // ****************************************
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
    endtask : settle

    task automatic wr(input int idx, input logic [7:0] v);
        logic [7:0] r;
        logic ok;
        u_host.access(1'b1, 16'(`TCCB_OFS_EVT_COMMS + idx), v, r, ok);
        if (idx >= 0 && idx < 8) begin
            mem[idx] = v & MASK[idx*8 +: 8];
        end
    endtask : wr

    task automatic rdchk(input int idx);
        logic [7:0] r;
        logic ok;
        u_host.access(1'b0, 16'(`TCCB_OFS_EVT_COMMS + idx), 8'h00, r, ok);
        chk("rvalid", 1, ok);
        chk("rdata", (idx >= 0 && idx < 8) ? mem[idx] : 8'h00, r);
    endtask : rdchk

    task automatic check_cfg();
        logic [15:0] c0, c1;
        logic [31:0] w;
        int mode, tr, ap;
        settle();
        c0 = {mem[1], mem[0]};
        c1 = {mem[3], mem[2]};
        w = {mem[7], mem[6], mem[5], mem[4]};
        mode = c0[7] ? host_mode : auto_mode;
        tr = (c1[13:12] == 0) ? 0 : c1[13:12] * 10 + ((c1[7:6] != 0) ? 10 : 0);
        ap = (mode == 3 && c1[4]) ? aptab[c1[1:0]] : (mode == 4 && c1[5]) ? aptab[c1[3:2]] : 0;
        chk("power_mode", mode, power_mode_o);
        chk("manual", c0[7], mode_manual_o);
        chk("sleep_conv", c0[5], sleep_conv_o);
        chk("retune_en", c0[3:2], {wake_retune_en_o, surf_retune_en_o});
        chk("full_tune", c0[1], wake_full_tune_o);
        chk("light_sleep", c0[0], light_sleep_o);
        chk("switch", c1[15] && (switch_pin == c1[14]), switch_active_o);
        chk("trim", tr, prox_trim_pct_o);
        chk("main_osc", c1[7:6], main_osc_sel_o);
        chk("autoprox", ap, autoprox_cycles_o);
        chk("wake_sensed", w[31] && (mode inside {3, 4}), wake_sensed_o);
        chk("filt_mutual", w[30:29], {wake_filter_o, wake_mutual_o});
        chk("shield", w[28] && !w[29], wake_shield_o);
        chk("rx_sel", w[25:0], wake_rx_sel_o);
    endtask : check_cfg

    task automatic cyc_end(input logic ap, input logic exp);
        @(posedge clk_i);
        #1;
        cycle_end = 1'b1;
        auto_prox = ap;
        @(posedge clk_i);
        #1;
        cycle_end = 1'b0;
        chk("window", exp, window_open_o);
    endtask : cyc_end

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        summarize();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(32'h67990c4a));
        for (int i = 0; i < 8; i++) begin
            mem[i] = RST[i*8 +: 8];
        end
        repeat (12) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        check_cfg();
        for (int i = -1; i < 9; i++) begin
            rdchk(i);
        end
        for (int n = 0; n < 20; n++) begin
            auto_mode = 3'($urandom_range(4, 0));
            switch_pin = 1'($urandom());
            u_host.set_host(1'b0, 3'($urandom_range(4, 0)));
            for (int i = -1; i < 9; i++) begin
                wr(i, 8'($urandom()));
            end
            check_cfg();
            for (int i = -1; i < 9; i++) begin
                rdchk(i);
            end
        end
        for (int k = 0; k < 14; k++) begin
            d = 8'($urandom());
            d[k % 7 + 1] = k[0];
            d[0] = 1'b0;
            wr(1, d);
            @(posedge clk_i);
            #1;
            cause = 7'(1 << (k % 7));
            @(posedge clk_i);
            #1;
            cause = 7'h00;
            chk("event", d[k % 7 + 1], event_o);
        end
        wr(1, 8'h00);
        wr(0, 8'h0c);
        cyc_end(1'b1, 1'b0);
        cyc_end(1'b0, 1'b1);
        u_host.cmd(0);
        chk("window", 0, window_open_o);
        u_host.set_host(1'b1, 3'h0);
        settle();
        chk("stretch", 1, stretch_o);
        wr(0, 8'h5c);
        settle();
        chk("stretch", 0, stretch_o);
        u_host.set_host(1'b0, 3'h0);
        cyc_end(1'b0, 1'b1);
        u_host.cmd(0);
        chk("window", 1, window_open_o);
        u_host.cmd(1);
        u_host.cmd(0);
        chk("window", 0, window_open_o);
        wr(1, 8'h03);
        cyc_end(1'b0, 1'b0);
        @(posedge clk_i);
        #1;
        cause = 7'h01;
        @(posedge clk_i);
        #1;
        cause = 7'h00;
        cyc_end(1'b0, 1'b1);
        u_host.cmd(1);
        u_host.cmd(0);
        chk("window", 0, window_open_o);
        u_host.cmd(2);
        cyc_end(1'b0, 1'b1);
        summarize();
    end
endmodule : tb_touch_controller_config_bank
